// File: rtl/uir_pkg.sv
// Package for the universal input readout: modes, settings, timing counts.
// Assumes a 250 MHz system clock; all counts derive from that rate.
package uir_pkg;
    localparam int CLK_MHZ            = 250;
    // Analog sample period 1.1(1) ms
    localparam int SAMPLE_PERIOD_NS   = 1111111;
    localparam int SAMPLE_CYC         = SAMPLE_PERIOD_NS * CLK_MHZ / 1000;
    // Discrete debounce 100 ms
    localparam int DISC_DEB_MS        = 100;
    localparam int DISC_DEB_CYC       = DISC_DEB_MS * CLK_MHZ * 1000;
    // Edge debounce choices in ns (least times round up)
    localparam int DEB1_NS            = 111;
    localparam int DEB2_NS            = 1780;
    localparam int DEB3_NS            = 14220;
    localparam int DEB1_CYC           = (DEB1_NS * CLK_MHZ + 999) / 1000;
    localparam int DEB2_CYC           = (DEB2_NS * CLK_MHZ + 999) / 1000;
    localparam int DEB3_CYC           = (DEB3_NS * CLK_MHZ + 999) / 1000;
    // Averaging lengths
    localparam int AVG_50             = 18;
    localparam int AVG_60             = 15;
    localparam int AVG_BOTH           = 90;
    localparam int AVG_DEPTH          = 128;
    localparam int AVG_AW             = 7;
    // Frequency limits in millihertz
    localparam longint FLO_LOW_MHZ    = 9155;
    localparam longint FHI_LOW_MHZ    = 1200000;
    localparam longint FLO_HIGH_MHZ   = 91550;
    localparam longint FHI_HIGH_MHZ   = 12000000;
    // Period limits in cycles: below-range is a period longer than this
    localparam longint PER_MAX_LOW    = longint'(1000000000) * CLK_MHZ / FLO_LOW_MHZ;
    localparam longint PER_MIN_LOW    = longint'(1000000000) * CLK_MHZ / FHI_LOW_MHZ;
    localparam longint PER_MAX_HIGH   = longint'(1000000000) * CLK_MHZ / FLO_HIGH_MHZ;
    localparam longint PER_MIN_HIGH   = longint'(1000000000) * CLK_MHZ / FHI_HIGH_MHZ;
    // Auto-range thresholds in ohm
    localparam int R_TH1              = 100;
    localparam int R_TH2              = 1100;
    localparam int R_TH3              = 11100;
    // Widths
    localparam int SW                 = 24;
    localparam int CW                 = 32;
    localparam int NW                 = 16;
    localparam logic [NW-1:0] NORM_ONE = 16'hffff;
    localparam logic [NW-1:0] NORM_ZERO = 16'h0000;
    localparam logic [1:0] ERR_LOW    = 2'h0;
    localparam logic [1:0] ERR_HIGH   = 2'h1;

    typedef enum logic [2:0] {
        UIR_MODE_OFF, UIR_MODE_VOLT, UIR_MODE_CURR, UIR_MODE_RES,
        UIR_MODE_DISC, UIR_MODE_FREQ, UIR_MODE_PWM
    } uir_mode_e;
    typedef enum logic [1:0] {UIR_FLT_OFF, UIR_FLT_50, UIR_FLT_60, UIR_FLT_BOTH} uir_flt_e;
    typedef enum logic [1:0] {UIR_DEB_OFF, UIR_DEB_1, UIR_DEB_2, UIR_DEB_3} uir_deb_e;
    typedef enum logic [1:0] {UIR_RNG_150, UIR_RNG_2K, UIR_RNG_20K, UIR_RNG_250K} uir_rng_e;
endpackage

// File: rtl/uir_avg_mem.sv
// Sample history memory for the running average, registered read data.
// Assumes one write and one read address per cycle, same clock.
`timescale 1ns/1ns
`default_nettype none
module uir_avg_mem (
    input  wire logic                         clk_sys_in,
    input  wire logic                         wr_en_in,
    input  wire logic [uir_pkg::AVG_AW-1:0]   wr_addr_in,
    input  wire logic [uir_pkg::SW-1:0]       wr_data_in,
    input  wire logic [uir_pkg::AVG_AW-1:0]   rd_addr_in,
    output logic      [uir_pkg::SW-1:0]       rd_data_out
);
    logic [uir_pkg::SW-1:0] mem [uir_pkg::AVG_DEPTH];

    // Write port and registered read
    always_ff @(posedge clk_sys_in) begin
        if (wr_en_in) begin
            mem[wr_addr_in] <= wr_data_in;
        end
        rd_data_out <= mem[rd_addr_in];
    end
endmodule
`default_nettype wire

// File: rtl/uir_readout.sv
// Universal input readout: analog averaging, ranging, frequency/PWM, discrete.
// Assumes ADC samples and comparator level arrive synchronous to clk_sys_in.
//
// Overview of operation
// - Analog modes sample once every 1.1(1) ms.
// - Running average chosen by filter setting; disabled passes raw samples.
// - Average spans 18, 15 or 90 samples for 50, 60, both.
// - Voltage mode uses lower and upper voltage limits as window.
// - Current mode shares voltage path with current limits.
// - Auto range picks 150, 2k, 20k or 250k by resistance thresholds.
// - Range switching keeps conversion monotonic across boundaries.
// - Frequency and PWM apply configured input polarity.
// - Low range: error 0 below 9.155 Hz, error 1 at 1.2 kHz.
// - High range: error 0 below 91.55 Hz, error 1 at 12 kHz.
// - Out-of-range frequency or duty forces value to zero.
// - PWM carrier loss gives valid 0% or 100% by polarity and level.
// - Discrete mode debounces 100 ms and applies polarity.
// - Edge debounce selectable: off, 111 ns, 1.78 us, 14.22 us.
// - Frequency/PWM only on inputs 1 and 3; frequency on input 1 disables analog on the other inputs.
`timescale 1ns/1ns
`default_nettype none
module uir_readout #(
    parameter int INPUT_NUM    = 1,
    parameter int DISC_DEB_CYC = uir_pkg::DISC_DEB_CYC,
    parameter int SAMPLE_CYC   = uir_pkg::SAMPLE_CYC
) (
    input  wire logic                     clk_sys_in,
    input  wire logic                     rst_in,
    input  wire logic [2:0]               mode_in,
    input  wire logic                     freq_on_in1_in,
    input  wire logic [1:0]               filter_sel_in,
    input  wire logic [1:0]               debounce_sel_in,
    input  wire logic                     active_low_in,
    input  wire logic                     freq_high_range_in,
    input  wire logic                     auto_range_in,
    input  wire logic [1:0]               manual_range_in,
    input  wire logic [uir_pkg::SW-1:0]   adc_sample_in,
    input  wire logic                     level_in,
    input  wire logic [uir_pkg::SW-1:0]   lim_min_in,
    input  wire logic [uir_pkg::SW-1:0]   lim_max_in,
    output logic                          sample_req_out,
    output logic [1:0]                    res_range_out,
    output logic [uir_pkg::NW-1:0]        norm_out,
    output logic                          error_out,
    output logic [1:0]                    error_code_out,
    output logic                          disc_state_out,
    output logic                          valid_out,
    output logic                          mode_blocked_out
);
    localparam int SW = uir_pkg::SW;
    localparam int CW = uir_pkg::CW;
    localparam int NW = uir_pkg::NW;
    localparam int AW = uir_pkg::AVG_AW;

    typedef struct packed {
        logic [CW-1:0] smp_cnt;
        logic [AW-1:0] wptr;
        logic [AW-1:0] fill;
        logic [SW+AW-1:0] sum;
        logic          pend;
        logic [SW-1:0] meas;
        logic          meas_vld;
        logic [1:0]    rng;
        logic [CW-1:0] deb_cnt;
        logic          lvl;
        logic          lvl_d;
        logic [CW-1:0] per_cnt;
        logic [CW-1:0] hi_cnt;
        logic [CW-1:0] per;
        logic [CW-1:0] hi;
        logic          per_vld;
        logic          lost;
        logic [CW-1:0] dcnt;
        logic          disc;
        logic [NW-1:0] norm;
        logic          err;
        logic [1:0]    ecode;
        logic          vld;
    } uir_state_s;

    uir_state_s s_r;
    uir_state_s s_nxt;

    logic [SW-1:0] old_smp;
    logic [AW-1:0] avg_len;
    logic          freq_mode;
    logic          analog_mode;
    logic          blocked;
    logic          pin;
    logic [CW-1:0] deb_len;
    logic [CW-1:0] per_max;
    logic [CW-1:0] per_min;
    logic          smp_tick;
    logic [SW-1:0] val;
    logic [2*CW-1:0] tmp;

    // Old sample leaving the averaging window
    uir_avg_mem u_mem (
        .clk_sys_in (clk_sys_in),
        .wr_en_in   (s_r.pend),
        .wr_addr_in (s_r.wptr),
        .wr_data_in (adc_sample_in),
        .rd_addr_in (s_r.wptr),
        .rd_data_out(old_smp)
    );

    // Scale value into 0..1 between limits, clamped
    function automatic logic [NW-1:0] scale(input logic [SW-1:0] v,
                                            input logic [SW-1:0] lo,
                                            input logic [SW-1:0] hi);
        logic [SW+NW-1:0] num;
        logic [SW+NW-1:0] q;
        num = '0;
        q = '0;
        if (v <= lo || hi <= lo) begin
            scale = uir_pkg::NORM_ZERO;
        end else if (v >= hi) begin
            scale = uir_pkg::NORM_ONE;
        end else begin
            num = (SW+NW)'(v - lo) * (SW+NW)'(uir_pkg::NORM_ONE);
            q = num / (SW+NW)'(hi - lo);
            scale = q[NW-1:0];
        end
    endfunction

    // Mode decode and configuration selections
    always_comb begin
        freq_mode = (mode_in == uir_pkg::UIR_MODE_FREQ) || (mode_in == uir_pkg::UIR_MODE_PWM);
        analog_mode = (mode_in == uir_pkg::UIR_MODE_VOLT) || (mode_in == uir_pkg::UIR_MODE_CURR)
                      || (mode_in == uir_pkg::UIR_MODE_RES);
        blocked = (freq_mode && INPUT_NUM != 1 && INPUT_NUM != 3)
                  || (analog_mode && INPUT_NUM != 1 && freq_on_in1_in);
        case (filter_sel_in)
            uir_pkg::UIR_FLT_50:   avg_len = AW'(uir_pkg::AVG_50);
            uir_pkg::UIR_FLT_60:   avg_len = AW'(uir_pkg::AVG_60);
            uir_pkg::UIR_FLT_BOTH: avg_len = AW'(uir_pkg::AVG_BOTH);
            default:               avg_len = AW'(1);
        endcase
        case (debounce_sel_in)
            uir_pkg::UIR_DEB_1: deb_len = CW'(uir_pkg::DEB1_CYC);
            uir_pkg::UIR_DEB_2: deb_len = CW'(uir_pkg::DEB2_CYC);
            uir_pkg::UIR_DEB_3: deb_len = CW'(uir_pkg::DEB3_CYC);
            default:            deb_len = '0;
        endcase
        per_max = freq_high_range_in ? CW'(uir_pkg::PER_MAX_HIGH) : CW'(uir_pkg::PER_MAX_LOW);
        per_min = freq_high_range_in ? CW'(uir_pkg::PER_MIN_HIGH) : CW'(uir_pkg::PER_MIN_LOW);
        pin = level_in ^ active_low_in;
        smp_tick = (s_r.smp_cnt == CW'(SAMPLE_CYC - 1));
    end

    // Next-state logic for all measurement paths
    always_comb begin
        s_nxt = s_r;
        val = '0;
        tmp = '0;
        // Sample period divider
        s_nxt.smp_cnt = smp_tick ? '0 : s_r.smp_cnt + CW'(1);
        s_nxt.pend = smp_tick && analog_mode && !blocked;
        s_nxt.meas_vld = 1'b0;
        // Running sum update one cycle after sample, old word out
        if (s_r.pend) begin
            if (s_r.fill >= avg_len) begin
                s_nxt.sum = s_r.sum + (SW+AW)'(adc_sample_in) - (SW+AW)'(old_smp);
            end else begin
                s_nxt.sum = s_r.sum + (SW+AW)'(adc_sample_in);
                s_nxt.fill = s_r.fill + AW'(1);
            end
            s_nxt.wptr = (s_r.wptr == avg_len - AW'(1)) ? '0 : s_r.wptr + AW'(1);
            s_nxt.meas_vld = 1'b1;
        end
        if (filter_sel_in == uir_pkg::UIR_FLT_OFF && s_r.meas_vld) begin
            s_nxt.meas = s_r.sum[SW-1:0];
        end else if (s_r.meas_vld) begin
            tmp = (2*CW)'(s_r.sum) / (2*CW)'((s_r.fill == '0) ? AW'(1) : s_r.fill);
            s_nxt.meas = tmp[SW-1:0];
        end
        // Auto ranging with hysteresis-free monotone thresholds
        if (auto_range_in) begin
            if (s_r.meas < SW'(uir_pkg::R_TH1))      s_nxt.rng = uir_pkg::UIR_RNG_150;
            else if (s_r.meas <= SW'(uir_pkg::R_TH2)) s_nxt.rng = uir_pkg::UIR_RNG_2K;
            else if (s_r.meas <= SW'(uir_pkg::R_TH3)) s_nxt.rng = uir_pkg::UIR_RNG_20K;
            else                                     s_nxt.rng = uir_pkg::UIR_RNG_250K;
        end else begin
            s_nxt.rng = manual_range_in;
        end
        // Edge debounce: level accepted after stable for deb_len + 1 cycles
        if (pin == s_r.lvl) begin
            s_nxt.deb_cnt = '0;
        end else if (s_r.deb_cnt >= deb_len) begin
            s_nxt.lvl = pin;
            s_nxt.deb_cnt = '0;
        end else begin
            s_nxt.deb_cnt = s_r.deb_cnt + CW'(1);
        end
        s_nxt.lvl_d = s_r.lvl;
        // Period and high-time capture on rising active edge
        s_nxt.per_cnt = (s_r.per_cnt == '1) ? s_r.per_cnt : s_r.per_cnt + CW'(1);
        if (s_r.lvl) s_nxt.hi_cnt = s_r.hi_cnt + CW'(1);
        if (s_r.lvl && !s_r.lvl_d) begin
            s_nxt.per = s_r.per_cnt;
            s_nxt.hi = s_r.hi_cnt;
            s_nxt.per_vld = 1'b1;
            s_nxt.lost = 1'b0;
            s_nxt.per_cnt = CW'(1);
            s_nxt.hi_cnt = CW'(1);
        end else if (s_r.per_cnt > per_max) begin
            s_nxt.lost = 1'b1;
            s_nxt.per_vld = 1'b0;
        end
        if (!freq_mode) begin
            s_nxt.per_vld = 1'b0;
        end
        // Discrete debounce fixed interval
        if (pin == s_r.disc) begin
            s_nxt.dcnt = '0;
        end else if (s_r.dcnt >= CW'(DISC_DEB_CYC - 1)) begin
            s_nxt.disc = pin;
            s_nxt.dcnt = '0;
        end else begin
            s_nxt.dcnt = s_r.dcnt + CW'(1);
        end
        // Output normalization per mode
        s_nxt.err = 1'b0;
        s_nxt.ecode = s_r.ecode;
        s_nxt.vld = 1'b1;
        if (blocked) begin
            s_nxt.norm = uir_pkg::NORM_ZERO;
            s_nxt.vld = 1'b0;
        end else begin
            case (mode_in)
                uir_pkg::UIR_MODE_VOLT, uir_pkg::UIR_MODE_CURR, uir_pkg::UIR_MODE_RES: begin
                    // Window bounds from limits; single linear scale stays monotone
                    s_nxt.norm = scale(s_r.meas, lim_min_in, lim_max_in);
                end
                uir_pkg::UIR_MODE_DISC: begin
                    s_nxt.norm = s_r.disc ? uir_pkg::NORM_ONE : uir_pkg::NORM_ZERO;
                end
                uir_pkg::UIR_MODE_FREQ, uir_pkg::UIR_MODE_PWM: begin
                    if (mode_in == uir_pkg::UIR_MODE_PWM && s_r.lost) begin
                        // Carrier loss reads as steady 0% or 100%
                        s_nxt.norm = scale(s_r.lvl ? SW'(100) : SW'(0),
                                           lim_min_in, lim_max_in);
                    end else if (s_r.lost || (s_r.per_vld && s_r.per > per_max)) begin
                        s_nxt.err = 1'b1;
                        s_nxt.ecode = uir_pkg::ERR_LOW;
                        s_nxt.norm = uir_pkg::NORM_ZERO;
                    end else if (s_r.per_vld && s_r.per <= per_min) begin
                        s_nxt.err = 1'b1;
                        s_nxt.ecode = uir_pkg::ERR_HIGH;
                        s_nxt.norm = uir_pkg::NORM_ZERO;
                    end else if (s_r.per_vld) begin
                        if (mode_in == uir_pkg::UIR_MODE_FREQ) begin
                            // Frequency in Hz from period
                            tmp = (2*CW)'(uir_pkg::CLK_MHZ * 1000000) / (2*CW)'(s_r.per);
                        end else begin
                            // Duty in percent
                            tmp = ((2*CW)'(s_r.hi) * (2*CW)'(100)) / (2*CW)'(s_r.per);
                        end
                        val = tmp[SW-1:0];
                        s_nxt.norm = scale(val, lim_min_in, lim_max_in);
                    end else begin
                        s_nxt.norm = uir_pkg::NORM_ZERO;
                        s_nxt.vld = 1'b0;
                    end
                end
                default: begin
                    s_nxt.norm = uir_pkg::NORM_ZERO;
                    s_nxt.vld = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Output mapping
    assign sample_req_out   = s_r.pend;
    assign res_range_out    = s_r.rng;
    assign norm_out         = s_r.norm;
    assign error_out        = s_r.err;
    assign error_code_out   = s_r.ecode;
    assign disc_state_out   = s_r.disc;
    assign valid_out        = s_r.vld;
    assign mode_blocked_out = blocked;
endmodule
`default_nettype wire

// File: verification/uir_src.sv
// Signal source model: ADC value on request, square wave on the level line.
// Assumes the bench changes value, period and high time away from a sample.
`timescale 1ns/1ns
`default_nettype none
module uir_src (
    input  wire logic                   clk_sys_in,
    input  wire logic                   rst_in,
    input  wire logic                   smp_req_in,
    input  wire logic [uir_pkg::SW-1:0] val_in,
    input  wire logic [31:0]            per_in,
    input  wire logic [31:0]            hi_in,
    input  wire logic                   hold_in,
    output logic      [uir_pkg::SW-1:0] adc_out,
    output logic                        level_out
);
    logic        req_d_r;
    logic [31:0] cnt_r;
    // Wave phase and request delay
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            req_d_r <= 1'b0;
            cnt_r   <= 32'h0;
        end else begin
            req_d_r <= smp_req_in;
            cnt_r   <= (cnt_r + 32'h1 >= per_in) ? 32'h0 : cnt_r + 32'h1;
        end
    end
    // Value only while read, inverse otherwise; stopped carrier holds a level
    assign adc_out   = (smp_req_in || req_d_r) ? val_in : ~val_in;
    assign level_out = (per_in == 32'h0) ? hold_in : (cnt_r < hi_in);
endmodule
`default_nettype wire

// File: verification/uir_readout_checker.sv
// Concurrent checks on the universal input readout ports.
// Assumes configuration is held static between resets.
`timescale 1ns/1ns
`default_nettype none
module uir_readout_checker #(
    parameter int SAMPLE_CYC   = 50,
    parameter int DISC_DEB_CYC = 20
) (
    input wire logic                   clk_sys_in,
    input wire logic                   rst_in,
    input wire logic [2:0]             mode_in,
    input wire logic                   active_low_in,
    input wire logic                   level_in,
    input wire logic                   sample_req_out,
    input wire logic [uir_pkg::NW-1:0] norm_out,
    input wire logic                   error_out,
    input wire logic                   disc_state_out,
    input wire logic                   valid_out,
    input wire logic                   mode_blocked_out
);
    logic        ana;
    logic        seen_r;
    logic [31:0] gap_r;
    logic [31:0] stab_r;
    logic        lvl_r;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // Analog mode decode
    assign ana = (mode_in == uir_pkg::UIR_MODE_VOLT) || (mode_in == uir_pkg::UIR_MODE_CURR)
              || (mode_in == uir_pkg::UIR_MODE_RES);
    // Cycles since last request, cycles the level has stood
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            seen_r <= 1'b0;
            gap_r  <= 32'h0;
            stab_r <= 32'h0;
            lvl_r  <= 1'b0;
        end else begin
            seen_r <= seen_r | sample_req_out;
            gap_r  <= sample_req_out ? 32'h1 : gap_r + 32'h1;
            stab_r <= (level_in == lvl_r) ? stab_r + 32'h1 : 32'h0;
            lvl_r  <= level_in;
        end
    end
    property p_req_gap;
        sample_req_out && seen_r |-> gap_r == SAMPLE_CYC;
    endproperty
    a_req_gap: assert property (p_req_gap) else $error("sample spacing wrong");
    property p_req_mode;
        sample_req_out |-> ana && !mode_blocked_out;
    endproperty
    a_req_mode: assert property (p_req_mode) else $error("sample outside analog mode");
    property p_norm_after_req;
        ana && $changed(norm_out) |-> $past(sample_req_out, 3);
    endproperty
    a_norm_after_req: assert property (p_norm_after_req) else $error("output moved off sample");
    property p_err_zero;
        error_out && $past(error_out) |-> norm_out == 16'h0000;
    endproperty
    a_err_zero: assert property (p_err_zero) else $error("value not zero in error");
    property p_err_mode;
        error_out |-> mode_in inside {uir_pkg::UIR_MODE_FREQ, uir_pkg::UIR_MODE_PWM};
    endproperty
    a_err_mode: assert property (p_err_mode) else $error("error outside frequency modes");
    property p_off_idle;
        mode_in == uir_pkg::UIR_MODE_OFF |-> !valid_out && !sample_req_out;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("disabled input active");
    property p_disc_deb;
        mode_in == uir_pkg::UIR_MODE_DISC && $changed(disc_state_out) |-> stab_r >= DISC_DEB_CYC - 2;
    endproperty
    a_disc_deb: assert property (p_disc_deb) else $error("discrete state changed early");
    property p_disc_pol;
        mode_in == uir_pkg::UIR_MODE_DISC && $changed(disc_state_out)
            |-> disc_state_out == (level_in ^ active_low_in);
    endproperty
    a_disc_pol: assert property (p_disc_pol) else $error("discrete polarity wrong");
endmodule
bind uir_readout uir_readout_checker #(
    .SAMPLE_CYC(SAMPLE_CYC), .DISC_DEB_CYC(DISC_DEB_CYC)
) u_uir_readout_checker (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(mode_in),
    .active_low_in(active_low_in), .level_in(level_in), .sample_req_out(sample_req_out),
    .norm_out(norm_out), .error_out(error_out), .disc_state_out(disc_state_out),
    .valid_out(valid_out), .mode_blocked_out(mode_blocked_out)
);
`default_nettype wire

// File: verification/tb_uir_readout.sv
// Self-checking bench for the universal input readout with a signal source.
// Assumes shortened sample period and discrete debounce counts.
`timescale 1ns/1ns
`default_nettype none
module tb_uir_readout;
    logic        clk_sys_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [2:0]  mode_in = 3'h0;
    logic        freq_on_in1_in = 1'b0;
    logic [1:0]  filter_sel_in = 2'h0;
    logic [1:0]  debounce_sel_in = 2'h0;
    logic [1:0]  manual_range_in = 2'h0;
    logic        active_low_in = 1'b0;
    logic        freq_high_range_in = 1'b0;
    logic        auto_range_in = 1'b0;
    logic [23:0] lim_min_in = 24'h0;
    logic [23:0] lim_max_in = 24'h1;
    logic [23:0] val = 24'h0;
    logic [31:0] per = 32'h0;
    logic [31:0] hi = 32'h0;
    logic        hold = 1'b0;
    logic [23:0] adc_sample_in;
    logic        level_in, sample_req_out, error_out, disc_state_out, valid_out, blk;
    logic [1:0]  res_range_out, error_code_out;
    logic [15:0] norm_out;
    int          fail_count = 0;
    int          n_compared = 0;
    int          n, lo, v, prev;
    longint      rv[8] = '{50, 99, 100, 1100, 1101, 11100, 11101, 200000};
    uir_readout #(.INPUT_NUM(1), .DISC_DEB_CYC(20), .SAMPLE_CYC(50)) u_uir_readout (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .mode_in(mode_in),
        .freq_on_in1_in(freq_on_in1_in), .filter_sel_in(filter_sel_in),
        .debounce_sel_in(debounce_sel_in), .active_low_in(active_low_in),
        .freq_high_range_in(freq_high_range_in), .auto_range_in(auto_range_in),
        .manual_range_in(manual_range_in), .adc_sample_in(adc_sample_in), .level_in(level_in),
        .lim_min_in(lim_min_in), .lim_max_in(lim_max_in), .sample_req_out(sample_req_out),
        .res_range_out(res_range_out), .norm_out(norm_out), .error_out(error_out),
        .error_code_out(error_code_out), .disc_state_out(disc_state_out),
        .valid_out(valid_out), .mode_blocked_out(blk));
    uir_src u_uir_src (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .smp_req_in(sample_req_out),
        .val_in(val), .per_in(per), .hi_in(hi), .hold_in(hold), .adc_out(adc_sample_in),
        .level_out(level_in));
    // 250 MHz clock
    always #2 clk_sys_in = ~clk_sys_in;
    // Window scaling, clamped
    function automatic longint sc(input longint x, input longint a, input longint b);
        if (x <= a) return 0;
        if (x >= b) return 65535;
        return (x - a) * 65535 / (b - a);
    endfunction
    // Range for a resistance
    function automatic logic [1:0] rng(input longint r);
        return (r < 100) ? 2'h0 : (r <= 1100) ? 2'h1 : (r <= 11100) ? 2'h2 : 2'h3;
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input int tol);
        logic [31:0] d;
        d = (seen > exp) ? seen - exp : exp - seen;
        n_compared++;
        if ((^seen === 1'bx) || (d > tol)) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cfg(input logic [2:0] m, input logic [1:0] f, input logic al,
                       input logic ar, input int a, input int b);
        rst_in <= 1'b1;
        mode_in <= m;
        filter_sel_in <= f;
        active_low_in <= al;
        auto_range_in <= ar;
        lim_min_in <= 24'(a);
        lim_max_in <= 24'(b);
        freq_on_in1_in <= (m >= 3'h5);
        freq_high_range_in <= (m == 3'h5) | 1'($urandom_range(1));
        debounce_sel_in <= 2'($urandom_range(3));
        manual_range_in <= 2'($urandom_range(3));
        repeat (10) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask
    // Wait k sample requests and let the output land
    task automatic smp(input int k);
        int w;
        repeat (k) begin
            w = 0;
            do begin
                @(negedge clk_sys_in);
                w++;
            end while (sample_req_out !== 1'b1 && w < 200);
            chk(32'(w < 200), 32'h1, 0); // Request in time
        end
        repeat (4) @(posedge clk_sys_in);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clk_sys_in);
        fail_count++;
        summarize();
    end
    // Main sequence
    initial begin
        void'($urandom(32'hbea0));
        for (int m = 1; m <= 2; m++) begin
            lo = 1000 + $urandom_range(3000);
            cfg(3'(m), 2'h0, 1'b0, 1'b0, lo, lo + 4000);
            for (int i = 0; i < 8; i++) begin
                v = (i == 0) ? lo - 1 : (i == 1) ? lo : (i == 2) ? lo + 4000 :
                    (i == 3) ? lo + 4001 : lo + $urandom_range(4000);
                val <= 24'(v);
                smp(1);
                chk(32'(norm_out), 32'(sc(v, lo, lo + 4000)), (i < 4) ? 0 : 1); // Window
            end
            $display("test window mode %0d done", m);
        end
        for (int f = 1; f <= 3; f++) begin
            n = (f == 1) ? 18 : (f == 2) ? 15 : 90;
            cfg(3'h1, 2'(f), 1'b0, 1'b0, 0, 360000);
            val <= 24'h0;
            smp(1);
            val <= 24'(360000);
            smp(n - 1);
            chk(32'(norm_out), 32'(sc(360000 * (n - 1) / n, 0, 360000)), 2); // One old point
            smp(1);
            chk(32'(norm_out), 32'hffff, 0); // Window full of new
            $display("test filter %0d done", f);
        end
        cfg(3'h3, 2'h0, 1'b0, 1'b1, 0, 250000);
        prev = 32'h0;
        for (int i = 0; i < 8; i++) begin
            val <= 24'(rv[i]);
            smp(1);
            chk(32'(res_range_out), 32'(rng(rv[i])), 0); // Auto range
            chk(32'(norm_out >= prev), 32'h1, 0); // No reversal
            prev = 32'(norm_out);
        end
        cfg(3'h3, 2'h0, 1'b0, 1'b0, 0, 250000);
        smp(1);
        chk(32'(res_range_out), 32'(manual_range_in), 0); // Manual range kept
        $display("test resistance done");
        for (int al = 0; al <= 1; al++) begin
            hold <= 1'b0;
            cfg(3'h4, 2'h0, 1'(al), 1'b0, 0, 1);
            hold <= 1'b1;
            repeat (10) @(posedge clk_sys_in);
            hold <= 1'b0;
            repeat (40) @(posedge clk_sys_in);
            chk(32'(disc_state_out), 32'(al), 0); // Bounce ignored
            hold <= 1'b1;
            repeat (40) @(posedge clk_sys_in);
            chk(32'(disc_state_out), 32'(1 - al), 0); // Polarity applied
            chk(32'(norm_out), al ? 32'h0 : 32'hffff, 0); // Discrete output level
            $display("test discrete %0d done", al);
        end
        cfg(3'h0, 2'h0, 1'b0, 1'b0, 0, 1);
        repeat (100) @(posedge clk_sys_in);
        chk(32'(valid_out), 32'h0, 0); // Disabled input idle
        per <= 32'd20834;
        hi <= 32'd10417;
        cfg(3'h5, 2'h0, 1'($urandom_range(1)), 1'b0, 0, 12000);
        repeat (45400) @(posedge clk_sys_in);
        chk(32'(error_out), 32'h0, 0); // Just under 12 kHz
        chk(32'(norm_out), 32'd65533, 8); // Frequency limits
        per <= 32'd20833;
        hi <= 32'd10416;
        repeat (21000) @(posedge clk_sys_in);
        chk(32'(error_out), 32'h1, 0); // At 12 kHz
        chk(32'(error_code_out), 32'(uir_pkg::ERR_HIGH), 0); // Above range code
        chk(32'(norm_out), 32'h0, 0); // Forced zero
        chk(32'(blk), 32'h0, 0);
        per <= 32'h0;
        $display("test frequency done");
        summarize();
    end
endmodule
`default_nettype wire
